/* File: dv/flash_host_monitor.sv */
// Purpose: pin protocol checks for the flash host controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every flash_host instance
`timescale 1ns/10ps
`default_nettype none
module flash_host_monitor (
  // clock and reset
  input wire logic                              clk,
  input wire logic                              rstn,
  // user command
  input wire logic                              cmd_valid,
  input wire flash_host_pkg::op_e               cmd_op,
  input wire logic                              cmd_ready,
  // flash pins
  input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_o,
  input wire logic                              flash_dq_oe,
  input wire logic                              flash_ce_n,
  input wire logic                              flash_oe_n,
  input wire logic                              flash_we_n
);
  import flash_host_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  //////////////////////////////////////////////////////////////////////
  // pin level relations
  drive_gate_a :
    assert property (flash_dq_oe |-> flash_oe_n && !flash_ce_n)
    else $error("data driven outside a write");
  write_inhibit_a :
    assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select");
  read_select_a :
    assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe && flash_we_n)
    else $error("read enable with bad control");
  strobe_width_a :
    assert property ($fell(flash_we_n) |-> (!flash_we_n)[*5] ##1 flash_we_n)
    else $error("write strobe width wrong");
  word_hold_a :
    assert property (!flash_we_n |=> flash_we_n || ($stable(flash_addr) && $stable(flash_dq_o)))
    else $error("address or data moved in strobe");
  read_length_a :
    assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*8] ##1 !flash_oe_n ##1 flash_oe_n)
    else $error("read cycle length wrong");

  //////////////////////////////////////////////////////////////////////
  // command sequence relations
  prog_unlock_a :
    assert property (cmd_valid && cmd_ready && cmd_op == OP_PROGRAM |-> ##[1:12]
      ($fell(flash_we_n) && flash_addr == UNLOCK_ADDR_1 && flash_dq_o == CODE_UNLOCK_1))
    else $error("program not opened by unlock");
  sector_align_a :
    assert property ($fell(flash_we_n) && flash_dq_o == CODE_SECTOR |-> flash_addr[11:0] == 12'h000)
    else $error("sector address not aligned");
  chip_addr_a :
    assert property ($fell(flash_we_n) && flash_dq_o == CODE_CHIP |-> flash_addr == UNLOCK_ADDR_1)
    else $error("chip erase at wrong address");

  // main scenarios reached
  cover property (cmd_valid && cmd_ready && cmd_op == OP_CHIP);
  cover property ($fell(flash_we_n) && flash_dq_o == CODE_QUERY);
  cover property (cmd_valid && cmd_ready && cmd_op == OP_EXIT3);
endmodule

bind flash_host flash_host_monitor mon_u (
  .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_ready(cmd_ready), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n)
);
`default_nettype wire

/* File: dv/flash_host_test.sv */
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural flash model on the pins
// Notes:   erase limit shortened to 200 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module flash_host_test;
  import flash_host_pkg::*;
  logic              clk, rstn, cmd_valid, slow, cmd_ready, rsp_valid, rsp_err;
  logic              id_mode, query_mode, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  op_e               cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, flash_dq_o, model_dq, dq_bus;
  int                fail_count, tests_run, cycles;

  // wire level: host during writes, model otherwise
  assign dq_bus = flash_dq_oe ? flash_dq_o : model_dq;

  flash_host #(.ERASE_LIMIT(200)) dut_u (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .id_mode(id_mode),
    .query_mode(query_mode), .flash_addr(flash_addr), .flash_dq_i(dq_bus),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
  flash_model model_u (.clk(clk), .rstn(rstn), .slow(slow), .addr(flash_addr),
    .dq_in(dq_bus), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_out(model_dq));

  // clock and run ceiling
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // one command, then wait for its response pulse
  task automatic do_cmd(input op_e op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK(rsp_valid, 1'b1)
  endtask
  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    do_cmd(OP_READ, a, 8'h00);
    `CHK(rsp_data, e)
  endtask
  task automatic erase_chk(input op_e op, input logic [ADDR_W-1:0] a);
    do_cmd(op, a, 8'h00);
    `CHK(rsp_err, 1'b0)
    `CHK(rsp_data[7], 1'b1)
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_program;
    logic [ADDR_W-1:0] pa [2] = '{21'h01234, 21'h20100};
    logic [DATA_W-1:0] pd [2] = '{8'h5a, 8'ha5};
    for (int i = 0; i < 2; i++) begin
      do_cmd(OP_PROGRAM, pa[i], pd[i]);
      `CHK(rsp_err, 1'b0)
      `CHK(rsp_data, pd[i])
      read_chk(pa[i], pd[i]);
    end
    do_cmd(OP_PROGRAM, 21'h21000, 8'h3c);
    `CHK(rsp_err, 1'b0)
  endtask
  task automatic t_erase;
    erase_chk(OP_SECTOR, 21'h20fff);
    read_chk(21'h20100, 8'hff);
    read_chk(21'h21000, 8'h3c);
    erase_chk(OP_BLOCK, 21'h2ffff);
    read_chk(21'h21000, 8'hff);
    read_chk(21'h01234, 8'h5a);
    erase_chk(OP_CHIP, 21'h00000);
    read_chk(21'h01234, 8'hff);
  endtask
  task automatic t_modes;
    do_cmd(OP_ID, 21'h00000, 8'h00);
    `CHK(id_mode, 1'b1)
    read_chk(21'h00000, 8'h3c);
    read_chk(21'h00001, 8'h7e);
    do_cmd(OP_EXIT1, 21'h1f00f, 8'h00);
    `CHK(id_mode, 1'b0)
    read_chk(21'h00000, 8'hff);
    do_cmd(OP_QUERY, 21'h00000, 8'h00);
    `CHK(query_mode, 1'b1)
    read_chk(21'h00010, 8'h51);
    read_chk(21'h00010, 8'h51);
    do_cmd(OP_EXIT3, 21'h00000, 8'h00);
    `CHK(query_mode, 1'b0)
    read_chk(21'h00010, 8'hff);
    do_cmd(OP_ID, 21'h00000, 8'h00);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    `CHK(id_mode, 1'b0)
    read_chk(21'h00000, 8'hff);
  endtask
  task automatic t_timeout;
    slow <= 1'b1;
    do_cmd(OP_SECTOR, 21'h00000, 8'h00);
    slow <= 1'b0;
    `CHK(rsp_err, 1'b1)
    `CHK(rsp_data[7], 1'b0)
    repeat (400) @(posedge clk);
    read_chk(21'h00000, 8'hff);
  endtask

  // reset, then every scenario in turn
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_data = '0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_program();
    t_erase();
    t_modes();
    t_timeout();
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: dv/flash_model.sv */
// Purpose: behavioural byte-wide flash for the host bench
// Assumes: pins settle by the falling clock edge
// Notes:   works on negedge so it never races the host sampling
`timescale 1ns/10ps
`default_nettype none
module flash_model #(
  parameter int         PROG_BUSY  = 40,
  parameter int         ERASE_BUSY = 60,
  parameter int         SLOW_BUSY  = 400,
  parameter logic [7:0] MAKER_ID   = 8'h3c, // arbitrary
  parameter logic [7:0] PART_ID    = 8'h7e  // arbitrary
) (
  // clock, reset, pacing
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic                              slow,
  // flash pins
  input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  input  wire logic                              ce_n,
  input  wire logic                              oe_n,
  input  wire logic                              we_n,
  output logic [flash_host_pkg::DATA_W-1:0]      dq_out
);
  import flash_host_pkg::*;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] pdata, last, rd;
  logic              erasing, id_q, qry_q, tog, prev_we, prev_oe;
  int                step, busy;

  // drop stored bytes whose bits above sh match
  task automatic erase(input int a, input int sh);
    int keys[$];
    foreach (mem[k]) if ((k >> sh) == (a >> sh)) keys.push_back(k);
    foreach (keys[i]) mem.delete(keys[i]);
  endtask

  //////////////////////////////////////////////////////////////////////
  // sequence decoder, one word per accepted strobe
  task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic u1;
    logic u2;
    logic go;
    u1 = (a[14:0] == 15'h5555);
    u2 = (a[14:0] == 15'h2aaa);
    go = d == CODE_SECTOR || d == CODE_BLOCK || (d == CODE_CHIP && u1);
    case (step)
      0: begin
        step = (d == CODE_UNLOCK_1 && u1) ? 1 : 0;
        if (step == 0 && d == CODE_EXIT) {id_q, qry_q} = 2'b00;
      end
      1: step = (d == CODE_UNLOCK_2 && u2) ? 2 : 0;
      2: begin
        step = !u1 ? 0 : (d == CODE_PROGRAM) ? 3 : (d == CODE_ERASE) ? 4 : 0;
        if (u1 && d == CODE_ID) id_q = 1'b1;
        if (u1 && d == CODE_QUERY) qry_q = 1'b1;
        if (u1 && d == CODE_EXIT) {id_q, qry_q} = 2'b00;
      end
      3: begin
        mem[int'(a)] = (mem.exists(int'(a)) ? mem[int'(a)] : 8'hff) & d;
        pdata = d;
        erasing = 1'b0;
        busy = PROG_BUSY;
        step = 0;
      end
      4: step = (d == CODE_UNLOCK_1 && u1) ? 5 : 0;
      5: step = (d == CODE_UNLOCK_2 && u2) ? 6 : 0;
      default: begin
        step = 0;
        if (d == CODE_SECTOR) erase(int'(a), SECTOR_LSB);
        if (d == CODE_BLOCK) erase(int'(a), BLOCK_LSB);
        if (d == CODE_CHIP && u1) erase(0, ADDR_W);
        erasing = go ? 1'b1 : erasing;
        busy = !go ? 0 : slow ? SLOW_BUSY : ERASE_BUSY;
      end
    endcase
  endtask

  // read data: status while busy, id or query table, else array
  always @* begin
    if (busy > 0) rd = erasing ? {1'b0, tog, 6'h00} : {~pdata[7], tog, pdata[5:0]};
    else if (id_q) rd = addr[0] ? PART_ID : MAKER_ID;
    else if (qry_q) rd = (addr[7:0] == 8'h10) ? 8'h51 : 8'h00;
    else rd = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
  end

  // released lines show the inverse of the last value
  assign dq_out = (!oe_n && !ce_n) ? rd : ~last;

  // strobe sampling; a word is taken on the rising write strobe
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      step = 0;
      busy = 0;
      {id_q, qry_q, tog, erasing} = 4'h0;
      {prev_we, prev_oe} = 2'b11;
    end else begin
      if (busy > 0) busy--;
      if (prev_oe && !oe_n && !ce_n) tog = ~tog;
      if (!prev_we && we_n && !ce_n && oe_n && busy == 0) take(addr, dq_in);
      if (!oe_n && !ce_n) last = rd;
      prev_we = we_n;
      prev_oe = oe_n;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/flash_bus_if.sv */
// Purpose: one-word request path between the sequencer and the pin cycle engine
// Assumes: req is a level held until ack, ack is a one-cycle pulse
// Notes:   rdata is valid in the ack cycle of a read
`timescale 1ns/10ps
`default_nettype none
interface flash_bus_if;
  import flash_host_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              ack;
  logic [DATA_W-1:0] rdata;

  modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

/* File: hdl/flash_cycle.sv */
// Purpose: runs one read or write bus cycle on the flash pins
// Assumes: pins are registered, dq_i is synchronous to clk
// Notes:   oe_n stays high for the whole of a write, dq driven only then
`timescale 1ns/10ps
`default_nettype none
module flash_cycle (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // request side
  flash_bus_if.engine                             bus,
  // flash pins
  output logic [flash_host_pkg::ADDR_W-1:0]       addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  dq_i,
  output logic [flash_host_pkg::DATA_W-1:0]       dq_o,
  output logic                                    dq_oe,
  output logic                                    ce_n,
  output logic                                    oe_n,
  output logic                                    we_n
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    P_IDLE   = 3'h0,
    P_SETUP  = 3'h1,
    P_STROBE = 3'h2,
    P_HOLD   = 3'h3,
    P_REL    = 3'h4
  } phase_e;

  typedef struct packed {
    phase_e            ph;
    logic [7:0]        cnt;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } cyc_s;

  cyc_s s_q;
  cyc_s s_d;

  // cycle phases
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    case (s_q.ph)
      P_IDLE: begin
        if (bus.req) begin
          s_d.ph    = P_SETUP;
          s_d.wr    = bus.wr;
          s_d.addr  = bus.addr;
          s_d.dq_o  = bus.wdata;
          s_d.ce_n  = 1'b0;
          s_d.oe_n  = bus.wr;
          s_d.dq_oe = bus.wr;
          s_d.cnt   = bus.wr ? 8'(ADDR_SETUP_CYC - 1) : 8'(READ_CYCLE_CYC - 1);
        end
      end
      P_SETUP: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else if (s_q.wr) begin
          s_d.ph   = P_STROBE;
          s_d.we_n = 1'b0;
          s_d.cnt  = 8'(WE_PULSE_CYC - 1);
        end else begin
          s_d.ph    = P_REL;
          s_d.rdata = dq_i;
          s_d.ce_n  = 1'b1;
          s_d.oe_n  = 1'b1;
          s_d.ack   = 1'b1;
        end
      end
      P_STROBE: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else begin
          s_d.ph   = P_HOLD;
          s_d.we_n = 1'b1;               // data latched on this rise
        end
      end
      P_HOLD: begin
        s_d.ph    = P_REL;
        s_d.ce_n  = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.ack   = 1'b1;
      end
      P_REL: begin
        s_d.ph = P_IDLE;                 // gap lets the master drop req
      end
      default: begin
        s_d.ph = P_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q      <= '0;
      s_q.ph   <= P_IDLE;
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign bus.ack   = s_q.ack;
  assign bus.rdata = s_q.rdata;
  assign addr      = s_q.addr;
  assign dq_o      = s_q.dq_o;
  assign dq_oe     = s_q.dq_oe;
  assign ce_n      = s_q.ce_n;
  assign oe_n      = s_q.oe_n;
  assign we_n      = s_q.we_n;

endmodule
`default_nettype wire

/* File: hdl/flash_host.sv */
// Purpose: host controller issuing command sequences to a parallel flash
// Assumes: one command at a time, flash pins synchronous to clk
// Notes:   completion is found by toggle reads, checked by the complement bit
//
// Functional notes
// - program needs AA/5555, 55/2AAA, A0/5555, then address and data
// - erase needs six writes ending 30 sector, 50 block or 10 chip
// - query entry is AA/5555, 55/2AAA, 98/5555
// - query mode lasts until the exit command; query_mode also clears when an id entry completes
// - id entry is AA/5555, 55/2AAA, 90/5555; 0000 maker, 0001 device
// - exit is F0 anywhere, or AA/5555, 55/2AAA, F0/5555
`timescale 1ns/10ps
`default_nettype none
module flash_host #(
  parameter int unsigned ERASE_LIMIT = flash_host_pkg::ERASE_LIMIT_CYC
) (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // user command
  input  wire logic                               cmd_valid,
  input  wire flash_host_pkg::op_e                cmd_op,
  input  wire logic [flash_host_pkg::ADDR_W-1:0]  cmd_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  cmd_data,
  output logic                                    cmd_ready,
  // user response
  output logic                                    rsp_valid,
  output logic [flash_host_pkg::DATA_W-1:0]       rsp_data,
  output logic                                    rsp_err,
  output logic                                    id_mode,
  output logic                                    query_mode,
  // flash pins
  output logic [flash_host_pkg::ADDR_W-1:0]       flash_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  flash_dq_i,
  output logic [flash_host_pkg::DATA_W-1:0]       flash_dq_o,
  output logic                                    flash_dq_oe,
  output logic                                    flash_ce_n,
  output logic                                    flash_oe_n,
  output logic                                    flash_we_n
);
  import flash_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // sequence tables

  // number of bus writes for an operation
  function automatic logic [2:0] seq_len(input op_e op);
    case (op)
      OP_PROGRAM:                     seq_len = LEN_FOUR;
      OP_SECTOR, OP_BLOCK, OP_CHIP:   seq_len = LEN_SIX;
      OP_ID, OP_QUERY, OP_EXIT3:      seq_len = LEN_THREE;
      default:                        seq_len = LEN_ONE;
    endcase
  endfunction

  // address and data of one write of a sequence
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_e op, input logic [2:0] step,
                                                         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] third;
    logic [ADDR_W-1:0] region;
    third  = CODE_PROGRAM;
    region = a;
    case (op)
      OP_SECTOR: region = {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
      OP_BLOCK:  region = {a[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
      default:   region = a;
    endcase
    case (op)
      OP_ID:                        third = CODE_ID;
      OP_QUERY:                     third = CODE_QUERY;
      OP_EXIT3:                     third = CODE_EXIT;
      OP_SECTOR, OP_BLOCK, OP_CHIP: third = CODE_ERASE;
      default:                      third = CODE_PROGRAM;
    endcase
    if (op == OP_EXIT1) begin
      seq_word = {a, CODE_EXIT};
    end else begin
      case (step)
        3'h0:    seq_word = {UNLOCK_ADDR_1, CODE_UNLOCK_1};
        3'h1:    seq_word = {UNLOCK_ADDR_2, CODE_UNLOCK_2};
        3'h2:    seq_word = {UNLOCK_ADDR_1, third};
        3'h3:    seq_word = (op == OP_PROGRAM) ? {a, d} : {UNLOCK_ADDR_1, CODE_UNLOCK_1};
        3'h4:    seq_word = {UNLOCK_ADDR_2, CODE_UNLOCK_2};
        default: begin
          case (op)
            OP_SECTOR: seq_word = {region, CODE_SECTOR};
            OP_BLOCK:  seq_word = {region, CODE_BLOCK};
            default:   seq_word = {UNLOCK_ADDR_1, CODE_CHIP};
          endcase
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_SEQ     = 3'h1,
    S_WAIT    = 3'h2,
    S_POLL    = 3'h3,
    S_RECOVER = 3'h4
  } st_e;

  typedef struct packed {
    st_e               st;
    op_e               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [2:0]        step;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] baddr;
    logic [DATA_W-1:0] bdata;
    logic              have_prev;
    logic              prev_tog;
    logic [TMO_W-1:0]  tmo;
    logic [7:0]        rcv;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic              rsp_err;
    logic              id_mode;
    logic              query_mode;
  } host_s;

  host_s s_q;
  host_s s_d;

  flash_bus_if bus ();

  logic [ADDR_W+DATA_W-1:0] word;
  logic                     is_erase;
  logic                     expect_hi;
  logic [TMO_W-1:0]         limit;

  // current sequence word and polling targets
  always_comb begin
    word      = seq_word(s_q.op, s_q.step, s_q.addr, s_q.data);
    is_erase  = (s_q.op == OP_SECTOR) || (s_q.op == OP_BLOCK) || (s_q.op == OP_CHIP);
    expect_hi = is_erase ? 1'b1 : s_q.data[COMPLEMENT_BIT];
    limit     = is_erase ? TMO_W'(ERASE_LIMIT) : TMO_W'(PROG_LIMIT_CYC);
  end

  // sequencer
  always_comb begin
    s_d           = s_q;
    s_d.rsp_valid = 1'b0;
    case (s_q.st)
      S_IDLE: begin
        if (cmd_valid && s_q.cmd_ready) begin
          s_d.cmd_ready = 1'b0;
          s_d.op        = cmd_op;
          s_d.addr      = cmd_addr;
          s_d.data      = cmd_data;
          s_d.step      = 3'h0;
          s_d.st        = S_SEQ;
        end
      end
      S_SEQ: begin
        s_d.req   = 1'b1;
        s_d.wr    = (s_q.op != OP_READ);
        s_d.baddr = (s_q.op == OP_READ) ? s_q.addr : word[ADDR_W+DATA_W-1:DATA_W];
        s_d.bdata = word[DATA_W-1:0];
        s_d.st    = S_WAIT;
      end
      S_WAIT: begin
        if (bus.ack) begin
          s_d.req = 1'b0;
          if (s_q.op == OP_READ) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data  = bus.rdata;
            s_d.rsp_err   = 1'b0;
            s_d.cmd_ready = 1'b1;
            s_d.st        = S_IDLE;
          end else if (s_q.step + 3'h1 < seq_len(s_q.op)) begin
            s_d.step = s_q.step + 3'h1;
            s_d.st   = S_SEQ;
          end else if ((s_q.op == OP_PROGRAM) || is_erase) begin
            // last strobe has risen: status reads are now valid
            s_d.req       = 1'b1;
            s_d.wr        = 1'b0;
            s_d.baddr     = (s_q.op == OP_CHIP) ? UNLOCK_ADDR_1 : s_q.addr;
            s_d.have_prev = 1'b0;
            s_d.tmo       = '0;
            s_d.st        = S_POLL;
          end else begin
            // mode change, then one read cycle time of settling
            s_d.id_mode    = (s_q.op == OP_ID);
            s_d.query_mode = (s_q.op == OP_QUERY);
            s_d.rcv        = 8'(READ_CYCLE_CYC);
            s_d.st         = S_RECOVER;
          end
        end
      end
      S_POLL: begin
        // no command or exit is issued until the toggle stops or tmo reaches limit
        s_d.tmo = s_q.tmo + TMO_W'(1);
        if (bus.ack) begin
          s_d.req = 1'b0;
          if (s_q.have_prev && (bus.rdata[TOGGLE_BIT] == s_q.prev_tog)) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data  = bus.rdata;
            s_d.rsp_err   = (bus.rdata[COMPLEMENT_BIT] != expect_hi);
            s_d.cmd_ready = 1'b1;
            s_d.st        = S_IDLE;
          end else if (s_q.tmo >= limit) begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data  = bus.rdata;
            s_d.rsp_err   = 1'b1;
            s_d.cmd_ready = 1'b1;
            s_d.st        = S_IDLE;
          end else begin
            s_d.have_prev = 1'b1;
            s_d.prev_tog  = bus.rdata[TOGGLE_BIT];
            s_d.req       = 1'b1;
          end
        end
      end
      S_RECOVER: begin
        if (s_q.rcv != 8'h00) begin
          s_d.rcv = s_q.rcv - 8'h01;
        end else begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = '0;
          s_d.rsp_err   = 1'b0;
          s_d.cmd_ready = 1'b1;
          s_d.st        = S_IDLE;
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase
  end

  // state register; after reset the device is taken to be in array read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q           <= '0;
      s_q.st        <= S_IDLE;
      s_q.op        <= OP_READ;
      s_q.cmd_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // request path to the cycle engine
  assign bus.req   = s_q.req;
  assign bus.wr    = s_q.wr;
  assign bus.addr  = s_q.baddr;
  assign bus.wdata = s_q.bdata;

  // user outputs
  assign cmd_ready  = s_q.cmd_ready;
  assign rsp_valid  = s_q.rsp_valid;
  assign rsp_data   = s_q.rsp_data;
  assign rsp_err    = s_q.rsp_err;
  assign id_mode    = s_q.id_mode;
  assign query_mode = s_q.query_mode;

  ////////////////////////////////////////////////////////////////////////////
  // pin cycle engine

  flash_cycle u_cycle (
    .clk   (clk),
    .rstn  (rstn),
    .bus   (bus.engine),
    .addr  (flash_addr),
    .dq_i  (flash_dq_i),
    .dq_o  (flash_dq_o),
    .dq_oe (flash_dq_oe),
    .ce_n  (flash_ce_n),
    .oe_n  (flash_oe_n),
    .we_n  (flash_we_n)
  );

endmodule
`default_nettype wire

/* File: hdl/flash_host_pkg.sv */
// Purpose: shared constants and types for the parallel flash host controller
// Assumes: byte-wide asynchronous flash, 21 address lines, clk at 125 MHz
// Notes:   every timing count is derived from a time in its own unit
package flash_host_pkg;

  // bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;

  // clock
  localparam int CLK_PERIOD_NS = 8;

  // pin timing, least times round up to whole cycles
  localparam int ADDR_SETUP_NS   = 10;
  localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_NS       = 5;   // device ignores strobes shorter than this
  localparam int WE_PULSE_NS     = 40;  // kept far above the glitch limit
  localparam int WE_PULSE_CYC    = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_NS   = 70;  // read_cycle_time
  localparam int READ_CYCLE_CYC  = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // completion limits, longest times round down
  localparam int PROG_MAX_US     = 20;
  localparam int PROG_LIMIT_CYC  = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int ERASE_MAX_MS    = 128;
  localparam int ERASE_LIMIT_CYC = (ERASE_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TMO_W           = 24;

  // unlock addresses and command codes
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 21'h005555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 21'h002aaa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_1 = 8'haa;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_2 = 8'h55;
  localparam logic [DATA_W-1:0] CODE_PROGRAM  = 8'ha0;
  localparam logic [DATA_W-1:0] CODE_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] CODE_SECTOR   = 8'h30;
  localparam logic [DATA_W-1:0] CODE_BLOCK    = 8'h50;
  localparam logic [DATA_W-1:0] CODE_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] CODE_ID       = 8'h90;
  localparam logic [DATA_W-1:0] CODE_QUERY    = 8'h98;
  localparam logic [DATA_W-1:0] CODE_EXIT     = 8'hf0;

  // erase region address fields
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK_LSB  = 16;

  // status bit positions
  localparam int COMPLEMENT_BIT = 7;
  localparam int TOGGLE_BIT     = 6;

  // sequence lengths
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR  = 3'h4;
  localparam logic [2:0] LEN_SIX   = 3'h6;

  // user operations
  typedef enum logic [3:0] {
    OP_READ    = 4'h0,
    OP_PROGRAM = 4'h1,
    OP_SECTOR  = 4'h2,
    OP_BLOCK   = 4'h3,
    OP_CHIP    = 4'h4,
    OP_ID      = 4'h5,
    OP_QUERY   = 4'h6,
    OP_EXIT1   = 4'h7,
    OP_EXIT3   = 4'h8
  } op_e;

endpackage
